// ===== core/spie_consts.vh
`ifndef SPIE_CONSTS_VH
`define SPIE_CONSTS_VH
// serial clock baud divisor width and the value that triggers the glitch
`define SPIE_BAUD_W 8
`define SPIE_BAUD_ONE 8'h01
`define SPIE_BAUD_RST 8'h02
// number of chip selects
`define SPIE_NCS 4
// data word width
`define SPIE_DATA_W 8
// config field positions in the per-select packed vector
`define SPIE_CFG_BAUD_LSB 0
`define SPIE_CFG_POL_BIT 8
`define SPIE_CFG_NPHA_BIT 9
`define SPIE_CFG_HOLD_BIT 10
`define SPIE_CFG_W 11
`endif

// ===== core/spie_clkgen.v
`include "spie_consts.vh"
// baud divisor tick generator for the serial clock
module spie_clkgen #(
  parameter BW = `SPIE_BAUD_W
) (
  input wire clk_sys_i, // system clock
  input wire reset_i, // sync reset
  input wire run_i, // count while high
  input wire [BW-1:0] div_i, // baud divisor
  output reg tick_o // one-cycle half-period tick
);
  reg [BW-1:0] cnt_q; // half period counter

  // count up towards the divisor, tick and clear when the next count reaches it
  always @(posedge clk_sys_i)
  begin
    if (reset_i || !run_i)
    begin
      cnt_q <= {BW{1'b0}};
      tick_o <= 1'b0;
    end
    else if (cnt_q + {{(BW-1){1'b0}}, 1'b1} >= div_i)
    begin
      cnt_q <= {BW{1'b0}};
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + {{(BW-1){1'b0}}, 1'b1};
      tick_o <= 1'b0;
    end
  end
endmodule // spie_clkgen

// ===== core/spie_core.v
`include "spie_consts.vh"
module spie_core #(
  parameter NCS = `SPIE_NCS,
  parameter DW = `SPIE_DATA_W,
  parameter CW = `SPIE_CFG_W
) (
  input wire clk_sys_i, // system clock
  input wire reset_i, // sync reset, active high
  input wire enable_cmd_i, // enable pulse
  input wire disable_cmd_i, // disable pulse
  input wire soft_reset_bit_i, // soft reset pulse
  input wire master_mode_i, // 1 master, 0 slave
  input wire mode_fault_detect_disable_i, // 1 disables fault detect
  input wire [1:0] cs_sel_i, // active chip select
  input wire [NCS*CW-1:0] chip_select_config_i, // per-select config
  input wire [DW-1:0] wdata_i, // transmit word
  input wire wr_i, // write to holding register
  input wire sclk_pin_i, // serial clock pin (slave)
  input wire mosi_pin_i, // data in (slave)
  input wire miso_pin_i, // data in (master)
  input wire cs_n_pin_i, // select in (slave), low active
  output reg sclk_o, // serial clock out
  output reg sclk_oe_o, // serial clock drive enable
  output reg mosi_o, // data out (master)
  output reg miso_o, // data out (slave)
  output reg [NCS-1:0] cs_n_o, // selects out, low active
  output reg enabled_o, // block enabled status
  output reg transmit_empty_flag_o, // holding register empty
  output reg rx_full_o, // receive word ready
  output reg [DW-1:0] rdata_o // received word
);
  localparam ST_IDLE = 2'h0; // waiting
  localparam ST_SHIFT = 2'h1; // clocking bits
  localparam ST_DONE = 2'h2; // word finished
  localparam [3:0] BITS = DW[3:0]; // bits per word, cut to counter width

  // extract one select's config field
  function [CW-1:0] cfg_of;
    input [NCS*CW-1:0] v;
    input integer i;
    begin
      cfg_of = v[i*CW +: CW];
    end
  endfunction

  // synchronised pins
  reg [1:0] sclk_s_q, mosi_s_q, miso_s_q, csn_s_q;
  reg sclk_d1_q; // previous synced clock
  reg csn_d1_q; // previous synced select
  reg en_q; // enable state
  reg [DW-1:0] hold_q; // transmit holding register
  reg [DW-1:0] sh_q; // shift register
  reg [3:0] bitc_q; // bit counter
  reg [1:0] st_q; // master state
  reg phase_q; // half period phase
  reg extra_q; // pending extra pulse
  reg [1:0] last_cs_q; // select of previous word
  wire [CW-1:0] cfg = cfg_of(chip_select_config_i, cs_sel_i);
  wire [`SPIE_BAUD_W-1:0] baud = cfg[`SPIE_CFG_BAUD_LSB +: `SPIE_BAUD_W];
  wire pol = cfg[`SPIE_CFG_POL_BIT];
  wire npha = cfg[`SPIE_CFG_NPHA_BIT];
  wire tick;
  wire srst = reset_i || soft_reset_bit_i;

  // any select with divisor one, any with other
  reg any_one, any_other;
  integer k;
  always @*
  begin
    any_one = 1'b0;
    any_other = 1'b0;
    for (k = 0; k < NCS; k = k + 1)
    begin
      if (chip_select_config_i[k*CW +: `SPIE_BAUD_W] == `SPIE_BAUD_ONE)
        any_one = 1'b1;
      else
        any_other = 1'b1;
    end
  end

  // glitch condition on select change
  wire glitch = any_one && any_other && pol && !npha;
  // hang: select 0 held with fault detect on
  wire hang = chip_select_config_i[`SPIE_CFG_HOLD_BIT] &&
    !mode_fault_detect_disable_i;

  spie_clkgen #(.BW(`SPIE_BAUD_W)) u_clk (
    .clk_sys_i(clk_sys_i),
    .reset_i(srst),
    .run_i(st_q == ST_SHIFT),
    .div_i(baud),
    .tick_o(tick)
  );

  // two-flop pin synchronisers
  always @(posedge clk_sys_i)
  begin
    sclk_s_q <= {sclk_s_q[0], sclk_pin_i};
    mosi_s_q <= {mosi_s_q[0], mosi_pin_i};
    miso_s_q <= {miso_s_q[0], miso_pin_i};
    csn_s_q <= {csn_s_q[0], cs_n_pin_i};
    sclk_d1_q <= sclk_s_q[1];
    csn_d1_q <= csn_s_q[1];
  end

  // enable state
  always @(posedge clk_sys_i)
  begin
    if (srst)
      en_q <= 1'b0;
    else if (enable_cmd_i)
      en_q <= 1'b1;
    else if (disable_cmd_i && master_mode_i)
      en_q <= 1'b0;
  end

  // master may start a word
  wire m_start = en_q && master_mode_i && st_q == ST_IDLE &&
    !transmit_empty_flag_o && !hang;
  // slave loads at select fall, seen only through the synchroniser
  wire s_start = en_q && !master_mode_i && !transmit_empty_flag_o &&
    csn_d1_q && !csn_s_q[1];
  wire load = m_start;

  // holding register and empty flag
  always @(posedge clk_sys_i)
  begin
    if (srst)
    begin
      hold_q <= {DW{1'b0}};
      transmit_empty_flag_o <= 1'b1;
    end
    else
    begin
      // load into shifter sets the flag, write clears it
      if (wr_i && en_q)
      begin
        hold_q <= wdata_i;
        transmit_empty_flag_o <= 1'b0;
      end
      // writes while disabled vanish, flag stays as it was
      if (load)
        transmit_empty_flag_o <= 1'b1;
    end
  end

  // master shift engine
  always @(posedge clk_sys_i)
  begin
    if (srst)
    begin
      st_q <= ST_IDLE;
      sh_q <= {DW{1'b0}};
      bitc_q <= 4'h0;
      phase_q <= 1'b0;
      extra_q <= 1'b0;
      last_cs_q <= 2'h0;
      sclk_o <= 1'b0;
      sclk_oe_o <= 1'b0;
      mosi_o <= 1'b0;
      cs_n_o <= {NCS{1'b1}};
      rx_full_o <= 1'b0;
      rdata_o <= {DW{1'b0}};
    end
    else
    begin
      sclk_oe_o <= en_q && master_mode_i;
      case (st_q)
        ST_IDLE:
        begin
          sclk_o <= pol;
          if (m_start)
          begin
            sh_q <= hold_q;
            bitc_q <= 4'h0;
            phase_q <= 1'b0;
            mosi_o <= hold_q[DW-1];
            cs_n_o <= ~({{(NCS-1){1'b0}}, 1'b1} << cs_sel_i);
            extra_q <= glitch && (cs_sel_i != last_cs_q);
            last_cs_q <= cs_sel_i;
            st_q <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (tick)
          begin
            if (extra_q)
            begin
              sclk_o <= ~sclk_o; // spurious pulse edge
              if (sclk_o != pol)
                extra_q <= 1'b0;
            end
            else
            begin
              sclk_o <= ~sclk_o;
              phase_q <= ~phase_q;
              if (phase_q == npha)
                sh_q <= {sh_q[DW-2:0], miso_s_q[1]};
              else
                mosi_o <= sh_q[DW-1];
              if (phase_q)
              begin
                bitc_q <= bitc_q + 4'h1;
                if (bitc_q == BITS - 4'h1)
                  st_q <= ST_DONE;
              end
            end
          end
        end
        ST_DONE:
        begin
          sclk_o <= pol;
          rdata_o <= sh_q;
          rx_full_o <= 1'b1;
          if (!chip_select_config_i[cs_sel_i*CW + `SPIE_CFG_HOLD_BIT])
            cs_n_o <= {NCS{1'b1}};
          st_q <= ST_IDLE;
        end
        default:
          st_q <= ST_IDLE;
      endcase
      // slave side runs while enabled, even after disable
      if (!master_mode_i && en_q && !csn_s_q[1] && sclk_s_q[1] && !sclk_d1_q)
        rdata_o <= {rdata_o[DW-2:0], mosi_s_q[1]};
    end
  end

  // slave transmit data and status
  always @(posedge clk_sys_i)
  begin
    if (srst)
    begin
      miso_o <= 1'b0;
      enabled_o <= 1'b0;
    end
    else
    begin
      enabled_o <= en_q;
      if (s_start)
        miso_o <= hold_q[DW-1];
    end
  end
endmodule // spie_core

// ===== test/spie_chk_checker.sv
module spie_chk #(parameter NCS = 4, parameter CW = 11) (
  input wire clk_sys_i, reset_i, enable_cmd_i, disable_cmd_i, wr_i,
  input wire soft_reset_bit_i, master_mode_i, mode_fault_detect_disable_i,
  input wire [NCS*CW-1:0] chip_select_config_i,
  input wire sclk_o, enabled_o, transmit_empty_flag_o,
  input wire [NCS-1:0] cs_n_o
);
  timeunit 1ns; timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // select0 hold with fault detect on
  wire hang = master_mode_i && chip_select_config_i[10] && !mode_fault_detect_disable_i
    && !soft_reset_bit_i;
  // enabled_o trails the internal enable by one cycle: the enable that decides a
  // write at one edge is seen on enabled_o at the next sample
  a_rst_state: assert property ($fell(reset_i) |-> &cs_n_o && transmit_empty_flag_o && !enabled_o)
    else $error("reset state wrong");
  a_soft_rst: assert property (soft_reset_bit_i |=> !enabled_o && transmit_empty_flag_o && &cs_n_o)
    else $error("soft reset state wrong");
  a_slave_keep: assert property (enabled_o && !master_mode_i && disable_cmd_i
    && !soft_reset_bit_i ##1 !soft_reset_bit_i |=> enabled_o) else $error("slave disabled");
  a_off_nowr: assert property (wr_i && transmit_empty_flag_o && !soft_reset_bit_i
    ##1 !enabled_o |-> transmit_empty_flag_o) else $error("flag cleared while off");
  a_wr_ack: assert property (wr_i && transmit_empty_flag_o && !soft_reset_bit_i
    ##1 enabled_o |-> !transmit_empty_flag_o) else $error("write not taken");
  a_hold_stall: assert property (hang [*2] |-> $stable(sclk_o) && $stable(cs_n_o))
    else $error("transfer started");
  a_start_sel: assert property (wr_i && transmit_empty_flag_o && &cs_n_o && master_mode_i
    && !disable_cmd_i && !soft_reset_bit_i ##1 enabled_o && master_mode_i
    && mode_fault_detect_disable_i && !soft_reset_bit_i |=> !(&cs_n_o))
    else $error("no select");
endmodule // spie_chk

// ===== test/spie_peer.sv
module spie_peer (
  input wire sclk, cs_n, mosi, cap_rise,
  output logic miso,
  output int n_rx,
  output logic [7:0] rx_b
);
  timeunit 1ns; timeprecision 1ps;
  logic [7:0] sh = 8'h00; // shift register
  int nb = 0; // bits of this word
  initial
  begin
    n_rx = 0;
    miso = 1'b0;
    rx_b = 8'h00;
  end
  // deselect restarts the word, data line shows no stale value
  always @(posedge cs_n)
  begin
    nb = 0;
    miso = ~miso;
  end
  // capture on the sampling edge, launch on the other
  always @(sclk)
    if (!cs_n)
    begin
      if (sclk == cap_rise)
      begin
        sh = {sh[6:0], mosi};
        nb++;
        if (nb == 8)
        begin
          rx_b = sh;
          nb = 0;
          n_rx++;
        end
      end
      else miso = sh[7];
    end
endmodule // spie_peer

// ===== test/spie_core_tb.sv
module spie_core_tb;
  timeunit 1ns; timeprecision 1ps;
  logic clk_sys_i = 0, reset_i = 1, en = 0, dis = 0, srst = 0, mst = 1, wr = 0;
  logic mfd = 1; // fault detect off first
  logic [1:0] sel = 0;
  logic [43:0] cfg = 0;
  logic [7:0] wd = 0, rxb;
  wire sclk, mosi, miso, en_o, fl, oe, rxf;
  wire [3:0] csn;
  int n_mismatch = 0, n_checks = 0, nrx, n0;
  logic [7:0] q[$]; // expected words
  always #2 clk_sys_i = ~clk_sys_i;
  spie_core dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .enable_cmd_i(en),
    .disable_cmd_i(dis), .soft_reset_bit_i(srst), .master_mode_i(mst),
    .mode_fault_detect_disable_i(mfd), .cs_sel_i(sel), .chip_select_config_i(cfg),
    .wdata_i(wd), .wr_i(wr), .sclk_pin_i(1'b0), .mosi_pin_i(1'b0), .miso_pin_i(miso),
    .cs_n_pin_i(1'b1), .sclk_o(sclk), .sclk_oe_o(oe), .mosi_o(mosi), .miso_o(),
    .cs_n_o(csn), .enabled_o(en_o), .transmit_empty_flag_o(fl), .rx_full_o(rxf),
    .rdata_o());
  spie_peer peer (.sclk(sclk), .cs_n(csn[sel]), .mosi(mosi),
    .cap_rise(~(cfg[8+11*sel] ^ cfg[9+11*sel])), .miso(miso), .n_rx(nrx), .rx_b(rxb));
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (e !== g)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task test_done;
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // bounded wait: flag high if tgt < 0, else word count
  task wt(input int tgt);
    for (int i = 0; i < 4000 && (tgt < 0 ? fl !== 1'b1 : nrx < tgt); i++) cyc(1);
    if (tgt < 0 ? fl !== 1'b1 : nrx < tgt)
    begin
      n_mismatch++;
      test_done();
    end
  endtask
  task send(input logic [7:0] d, input bit go);
    wr <= 1;
    wd <= d;
    cyc(1);
    wr <= 0;
    if (go) q.push_back(d);
    cyc(1);
  endtask
  // each word seen by the peer against the oldest note
  // the wait lets the word settle on its port before it is read
  always @(nrx)
  begin
    #1;
    if (q.size() > 0) chk("mosi word", q.pop_front(), rxb);
    else chk("queued words", 8'h01, 8'(q.size()));
  end
  initial
  begin
    void'($urandom(80647));
    for (int i = 0; i < 4; i++) cfg[11*i +: 11] <= {3'b010, 8'($urandom_range(4, 1))};
    cyc(16);
    reset_i <= 0;
    en <= 1;
    cyc(1);
    en <= 0;
    for (int i = 0; i < 4; i++)
    begin
      sel <= 2'($urandom);
      send(8'($urandom), 1);
      wt(-1);
      send(8'($urandom), 1);
      wt(2*i+2);
      cyc(40);
    end
    // polarity 1, phase 0: every select kept at divisor one
    for (int i = 0; i < 4; i++) cfg[11*i +: 11] <= {3'b001, 8'h01};
    for (int i = 0; i < 2; i++)
    begin
      cyc(2);
      sel <= 2'(i);
      send(8'($urandom), 1);
      wt(9+i);
      cyc(40);
    end
    cyc(2); // transfer stopped before disable
    dis <= 1;
    cyc(1);
    dis <= 0;
    n0 = nrx;
    repeat (3)
    begin
      send(8'($urandom), 0);
      chk("empty flag", 8'h01, {7'h0, fl});
    end
    cyc(300);
    chk("words after disable", 8'(n0), 8'(nrx));
    en <= 1;
    cyc(1);
    en <= 0;
    send(8'h5a, 1);
    wt(n0+1);
    cyc(40);
    mfd <= 0;
    cfg[10] <= 1;
    sel <= 0;
    cyc(2);
    send(8'($urandom), 0);
    cyc(300);
    chk("stalled selects", 8'h0f, {4'h0, csn});
    chk("rx full before reset", 8'h01, {7'h0, rxf});
    chk("sclk drive before reset", 8'h01, {7'h0, oe});
    srst <= 1;
    mst <= 0;
    cyc(1);
    srst <= 0;
    cyc(1);
    chk("soft reset flag", 8'h01, {7'h0, fl});
    chk("soft reset rx full", 8'h00, {7'h0, rxf});
    chk("soft reset sclk drive", 8'h00, {7'h0, oe});
    en <= 1;
    cyc(1);
    en <= 0;
    cyc(1);
    dis <= 1;
    cyc(1);
    dis <= 0;
    cyc(2);
    chk("slave enabled", 8'h01, {7'h0, en_o});
    srst <= 1;
    cyc(1);
    srst <= 0;
    cyc(2);
    chk("slave stopped", 8'h00, {7'h0, en_o});
    test_done();
  end
endmodule // spie_core_tb
bind spie_core spie_chk #(.NCS(NCS), .CW(CW)) u_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
  .enable_cmd_i(enable_cmd_i), .disable_cmd_i(disable_cmd_i), .wr_i(wr_i),
  .soft_reset_bit_i(soft_reset_bit_i), .master_mode_i(master_mode_i),
  .mode_fault_detect_disable_i(mode_fault_detect_disable_i),
  .chip_select_config_i(chip_select_config_i), .sclk_o(sclk_o), .enabled_o(enabled_o),
  .transmit_empty_flag_o(transmit_empty_flag_o), .cs_n_o(cs_n_o));
